// ==== hw/watchdog_regs.svh ====
`ifndef WATCHDOG_REGS_SVH
`define WATCHDOG_REGS_SVH

// register addresses on the cpu register port
`define ADDR_W            12
`define ADDR_CTRL         12'hFF0
`define ADDR_UPPER        12'hFF1
`define ADDR_HIGH         12'hFF2
`define ADDR_LOW          12'hFF3
`define ADDR_IRQ_STATUS   12'hFF4
`define ADDR_IRQ_MASK     12'hFF5

// key and configuration bytes written to the control address
`define KEY_FIRST         8'h55
`define KEY_SECOND        8'hAA
`define STOP_OFF_CODE     8'h81
`define STOP_ON_CODE      8'h00

// counter values
`define COUNT_W           24
`define COUNT_RESET       24'hFFFFFF
`define COUNT_NO_REFRESH  24'h000002
`define COUNT_STEP        24'h000001
`define COUNT_TIMEOUT     24'h000000

// byte lanes of the 24-bit value
`define UPPER_MSB         23
`define UPPER_LSB         16
`define HIGH_MSB          15
`define HIGH_LSB          8
`define LOW_MSB           7
`define LOW_LSB           0

// reset-source flags, held as {power_on, stop, timeout, external}
`define FLAG_EXTERNAL     0
`define FLAG_TIMEOUT      1
`define FLAG_STOP         2
`define FLAG_POWER_ON     3
`define FLAGS_CLEAR       4'h0
`define FLAGS_POWER_ON    4'h8
`define FLAGS_EXTERNAL    4'h1
`define FLAGS_TO_RESET    4'h2
`define FLAGS_GPIO_RECOV  4'h4
`define FLAGS_TO_RECOV    4'h6
`define CTRL_RESERVED     4'h0

// interrupt status and mask layout
`define IRQ_W             3
`define IRQ_TIMEOUT       0
`define IRQ_RECOVERY      1
`define IRQ_ABORT         2
`define IRQ_NONE          3'h0

`define BYTE_ZERO         8'h00

`endif

// ==== hw/watchdog_pkg.sv ====
package watchdog_pkg;

    // unlock sequencer for the reload registers and stop-mode option
    typedef enum logic [2:0] {
        LK_IDLE,
        LK_KEY1,
        LK_KEY2,
        LK_HIGH,
        LK_LOW
    } lock_state_t;

    // whole state of the watchdog core
    typedef struct packed {
        logic              on;
        logic [23:0]       count;
        logic [23:0]       reload;
        logic              refresh_pend;
        lock_state_t       lock;
        logic              stop_off;
        logic [3:0]        flags;
        logic [2:0]        irq_status;
        logic [2:0]        irq_mask;
        logic [7:0]        rdata;
        logic              timeout_irq;
        logic              device_reset_req;
        logic              stop_recovery_req;
        logic              irq;
    } watchdog_state_t;

    // state of the oscillator tick extractor
    typedef struct packed {
        logic              sync1;
        logic              sync2;
        logic              last;
        logic              tick;
    } tick_state_t;

endpackage

// ==== hw/rc_tick_sync.sv ====
`timescale 1ns/100ps
`default_nettype none

module rc_tick_sync (
    input  wire logic clk_sys,
    input  wire logic srst,
    input  wire logic rc_osc,
    output logic      rc_tick
);

    watchdog_pkg::tick_state_t s_q;
    watchdog_pkg::tick_state_t s_d;

    // two-stage synchroniser, then rising-edge detect on the second stage
    always_comb begin
        s_d       = s_q;
        s_d.sync1 = rc_osc;
        s_d.sync2 = s_q.sync1;
        s_d.last  = s_q.sync2;
        s_d.tick  = s_q.sync2 & ~s_q.last;
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign rc_tick = s_q.tick;

endmodule

`default_nettype wire

// ==== hw/watchdog_downcounter.sv ====
`include "watchdog_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module watchdog_downcounter (
    // clock and synchronous power-on reset
    input  wire logic        clk_sys,
    input  wire logic        srst,

    // oscillator level and option inputs
    input  wire logic        rc_osc,
    input  wire logic        always_on_option,
    input  wire logic        timeout_reset_select,

    // cpu and chip-level events
    input  wire logic        refresh_pulse,
    input  wire logic        stop_mode,
    input  wire logic        debug_mode,
    input  wire logic        ext_reset_event,
    input  wire logic        gpio_recovery_event,

    // register port, read data one cycle after the strobe
    input  wire logic [11:0] addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    output logic      [7:0]  rdata,

    // time-out responses, each a one-cycle pulse
    output logic             timeout_irq,
    output logic             device_reset_req,
    output logic             stop_recovery_req,

    // status levels
    output logic             stop_osc_disable,
    output logic             watchdog_on,
    output logic             irq
);

    watchdog_pkg::watchdog_state_t s_q;
    watchdog_pkg::watchdog_state_t s_d;

    logic rc_tick;

    // one byte of a 24-bit value selected by register address
    function automatic logic [7:0] byte_at(input logic [23:0] value,
                                           input logic [11:0] a);
        logic [7:0] b;
        // unmapped addresses read as zero
        b = `BYTE_ZERO;
        case (a)
            `ADDR_UPPER: b = value[`UPPER_MSB:`UPPER_LSB];
            `ADDR_HIGH:  b = value[`HIGH_MSB:`HIGH_LSB];
            `ADDR_LOW:   b = value[`LOW_MSB:`LOW_LSB];
            default:     b = `BYTE_ZERO;
        endcase
        return b;
    endfunction

    // replace one byte of a 24-bit value selected by register address
    function automatic logic [23:0] put_byte(input logic [23:0] value,
                                             input logic [11:0] a,
                                             input logic [7:0]  b);
        logic [23:0] v;
        // other addresses leave the value untouched
        v = value;
        case (a)
            `ADDR_UPPER: v[`UPPER_MSB:`UPPER_LSB] = b;
            `ADDR_HIGH:  v[`HIGH_MSB:`HIGH_LSB] = b;
            `ADDR_LOW:   v[`LOW_MSB:`LOW_LSB] = b;
            default:     v = value;
        endcase
        return v;
    endfunction

    // oscillator edges brought into the system clock as one-cycle ticks
    rc_tick_sync u_tick (
        .clk_sys (clk_sys),
        .srst    (srst),
        .rc_osc  (rc_osc),
        .rc_tick (rc_tick)
    );

    // next-state logic: bus first, counter events after so that sets win
    always_comb begin
        logic frozen;
        logic timeout;
        logic abort;
        // working flags of this cycle
        frozen  = 1'b0;
        timeout = 1'b0;
        abort   = 1'b0;

        // hold state; pulses and read data default low
        s_d                   = s_q;
        s_d.rdata             = `BYTE_ZERO;
        s_d.timeout_irq       = 1'b0;
        s_d.device_reset_req  = 1'b0;
        s_d.stop_recovery_req = 1'b0;

        // register reads, data valid in the following cycle
        if (rd_en) begin
            case (addr)
                // status flags, cleared by the read
                `ADDR_CTRL: begin
                    s_d.rdata = {s_q.flags, `CTRL_RESERVED};
                    s_d.flags = `FLAGS_CLEAR;
                end
                // live count, not the stored reload
                `ADDR_UPPER, `ADDR_HIGH, `ADDR_LOW: begin
                    s_d.rdata = byte_at(s_q.count, addr);
                end
                // pending events, cleared by the read
                `ADDR_IRQ_STATUS: begin
                    s_d.rdata      = {5'h00, s_q.irq_status};
                    s_d.irq_status = `IRQ_NONE;
                end
                // enable bits of the level interrupt
                `ADDR_IRQ_MASK: begin
                    s_d.rdata = {5'h00, s_q.irq_mask};
                end
                default: s_d.rdata = `BYTE_ZERO;
            endcase
        end

        // register writes and the unlock sequencer
        if (wr_en) begin
            // mask loads in any lock state, yet still breaks an unlock
            if (addr == `ADDR_IRQ_MASK) begin
                s_d.irq_mask = wdata[`IRQ_W-1:0];
            end
            case (s_q.lock)
                // waiting for the first key
                watchdog_pkg::LK_IDLE: begin
                    if (addr == `ADDR_CTRL && wdata == `KEY_FIRST) begin
                        s_d.lock = watchdog_pkg::LK_KEY1;
                    end
                end
                // second key must follow at once
                watchdog_pkg::LK_KEY1: begin
                    if (addr == `ADDR_CTRL && wdata == `KEY_SECOND) begin
                        s_d.lock = watchdog_pkg::LK_KEY2;
                    end else begin
                        s_d.lock = watchdog_pkg::LK_IDLE;
                        abort    = 1'b1;
                    end
                end
                // third write picks the reload or the stop option
                watchdog_pkg::LK_KEY2: begin
                    s_d.lock = watchdog_pkg::LK_IDLE;
                    if (addr == `ADDR_UPPER) begin
                        s_d.reload = put_byte(s_q.reload, addr, wdata);
                        s_d.lock   = watchdog_pkg::LK_HIGH;
                    end else if (addr == `ADDR_CTRL && wdata == `STOP_OFF_CODE) begin
                        s_d.stop_off = 1'b1;
                    end else if (addr == `ADDR_CTRL && wdata == `STOP_ON_CODE) begin
                        s_d.stop_off = 1'b0;
                    end else begin
                        abort = 1'b1;
                    end
                end
                // high byte must follow the upper byte
                watchdog_pkg::LK_HIGH: begin
                    if (addr == `ADDR_HIGH) begin
                        s_d.reload = put_byte(s_q.reload, addr, wdata);
                        s_d.lock   = watchdog_pkg::LK_LOW;
                    end else begin
                        s_d.lock = watchdog_pkg::LK_IDLE;
                        abort    = 1'b1;
                    end
                end
                // low byte closes the reload sequence
                watchdog_pkg::LK_LOW: begin
                    s_d.lock = watchdog_pkg::LK_IDLE;
                    if (addr == `ADDR_LOW) begin
                        s_d.reload = put_byte(s_q.reload, addr, wdata);
                    end else begin
                        abort = 1'b1;
                    end
                end
                default: s_d.lock = watchdog_pkg::LK_IDLE;
            endcase
        end

        // refresh waits for the next oscillator tick
        if (refresh_pulse) begin
            s_d.refresh_pend = 1'b1;
        end

        // counter, advanced only on oscillator ticks
        // stop option freezes the counter while in stop mode
        frozen = stop_mode & s_q.stop_off;
        if (rc_tick && !frozen) begin
            s_d.refresh_pend = 1'b0;
            // first enable loads the reload value
            if (!s_q.on) begin
                if (s_q.refresh_pend || refresh_pulse || always_on_option) begin
                    s_d.on    = 1'b1;
                    s_d.count = s_q.reload;
                end
            end else if (debug_mode) begin
                // debugger holds the count at the reload value
                s_d.count = s_q.reload;
            end else if ((s_q.refresh_pend || refresh_pulse)
                         && s_q.count > `COUNT_NO_REFRESH) begin
                // refresh honoured only above the threshold
                s_d.count = s_q.reload;
            end else begin
                // zero steps on to all ones: only the reset response outside stop mode reloads after a time-out
                s_d.count = s_q.count - `COUNT_STEP;
                timeout   = (s_q.count == `COUNT_STEP);
            end
        end

        // time-out response selected by the option input
        if (timeout) begin
            if (!timeout_reset_select) begin
                // interrupt response keeps counting down
                s_d.timeout_irq               = 1'b1;
                s_d.flags[`FLAG_TIMEOUT]      = 1'b1;
            end else if (stop_mode) begin
                // reset response inside stop mode asks for recovery
                s_d.stop_recovery_req = 1'b1;
                s_d.flags             = `FLAGS_TO_RECOV;
                s_d.irq_status[`IRQ_RECOVERY] = 1'b1;
            end else begin
                // reset response outside stop mode reloads the count and stays on only with always_on_option
                s_d.device_reset_req = 1'b1;
                s_d.flags            = `FLAGS_TO_RESET;
                s_d.on               = always_on_option;
                s_d.count            = s_q.reload;
            end
            s_d.irq_status[`IRQ_TIMEOUT] = 1'b1;
        end

        // reset and recovery sources from the rest of the chip
        if (ext_reset_event) begin
            s_d.flags = `FLAGS_EXTERNAL;
        end else if (gpio_recovery_event) begin
            s_d.flags = `FLAGS_GPIO_RECOV;
            s_d.irq_status[`IRQ_RECOVERY] = 1'b1;
        end

        // a broken unlock is reported as an event
        if (abort) begin
            s_d.irq_status[`IRQ_ABORT] = 1'b1;
        end

        // level interrupt from the next status and mask
        s_d.irq = |(s_d.irq_status & s_d.irq_mask);
    end

    // power-on reset: counter and reload at all ones, power-on flag set
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            s_q            <= '0;
            s_q.count      <= `COUNT_RESET;
            s_q.reload     <= `COUNT_RESET;
            s_q.lock       <= watchdog_pkg::LK_IDLE;
            s_q.flags      <= `FLAGS_POWER_ON;
            s_q.irq_status <= `IRQ_NONE;
            s_q.irq_mask   <= `IRQ_NONE;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from the state flops
    assign rdata             = s_q.rdata;
    assign timeout_irq       = s_q.timeout_irq;
    assign device_reset_req  = s_q.device_reset_req;
    assign stop_recovery_req = s_q.stop_recovery_req;
    assign stop_osc_disable  = s_q.stop_off;
    assign watchdog_on       = s_q.on;
    assign irq               = s_q.irq;

endmodule

`default_nettype wire

// ==== test/watchdog_downcounter_assertions.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "watchdog_regs.svh"

module watchdog_checker (
    input wire logic        clk_sys,
    input wire logic        srst,
    input wire logic [11:0] addr,
    input wire logic        wr_en,
    input wire logic        rd_en,
    input wire logic [7:0]  rdata,
    input wire logic        timeout_reset_select,
    input wire logic        stop_mode,
    input wire logic        timeout_irq,
    input wire logic        device_reset_req,
    input wire logic        stop_recovery_req,
    input wire logic        stop_osc_disable,
    input wire logic        irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    // read data, response pulses, stop option changes and interrupt drop
    rdata_idle_a: assert property (!$past(rd_en) |-> rdata == 8'h00)
        else $error("read data outside read slot");
    irq_pulse_a: assert property (timeout_irq |=> !timeout_irq)
        else $error("interrupt request longer than one cycle");
    reset_pulse_a: assert property (device_reset_req |=> !device_reset_req)
        else $error("reset request longer than one cycle");
    one_response_a: assert property ($onehot0({timeout_irq, device_reset_req, stop_recovery_req}))
        else $error("two time-out responses at once");
    irq_mode_a: assert property (timeout_irq |-> !$past(timeout_reset_select))
        else $error("interrupt response in reset mode");
    reset_mode_a: assert property (device_reset_req |->
        $past(timeout_reset_select) && !$past(stop_mode))
        else $error("device reset in wrong mode");
    recov_mode_a: assert property (stop_recovery_req |->
        ($past(timeout_reset_select) && $past(stop_mode)) ##1 !stop_recovery_req)
        else $error("bad stop recovery request");
    stop_option_a: assert property ($changed(stop_osc_disable) |-> $past(wr_en) && $past(addr) == `ADDR_CTRL)
        else $error("stop option changed without control write");
    irq_clear_a: assert property ($fell(irq) |-> $past(rd_en) || $past(rd_en, 2) || $past(wr_en) || $past(wr_en, 2))
        else $error("interrupt dropped without access");
endmodule

bind watchdog_downcounter watchdog_checker i_chk (
    .clk_sys(clk_sys), .srst(srst), .addr(addr), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .timeout_reset_select(timeout_reset_select), .stop_mode(stop_mode),
    .timeout_irq(timeout_irq), .device_reset_req(device_reset_req),
    .stop_recovery_req(stop_recovery_req), .stop_osc_disable(stop_osc_disable), .irq(irq)
);
`default_nettype wire

// ==== test/cpu_model.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "watchdog_regs.svh"

module cpu_model (
    input  wire logic        clk_sys,
    input  wire logic [7:0]  rdata,
    output logic      [11:0] addr,
    output logic      [7:0]  wdata,
    output logic             wr_en,
    output logic             rd_en,
    output logic             refresh_pulse
);
    // bus idle at time zero
    initial begin
        addr = 12'h000;
        wdata = 8'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
        refresh_pulse = 1'b0;
    end

    // single-cycle write strobe
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk_sys);
        wr_en <= 1'b0;
    endtask

    // read strobe, data taken in the following cycle only
    task automatic rd(input logic [11:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk_sys);
        rd_en <= 1'b0;
        #1;
        d = rdata;
    endtask

    // keys then reload bytes, upper first, low last
    task automatic load(input logic [23:0] v);
        wr(`ADDR_CTRL, `KEY_FIRST);
        wr(`ADDR_CTRL, `KEY_SECOND);
        wr(`ADDR_UPPER, v[23:16]);
        wr(`ADDR_HIGH, v[15:8]);
        wr(`ADDR_LOW, v[7:0]);
    endtask

    // keys then stop-mode option byte
    task automatic stop_cfg(input logic [7:0] code);
        wr(`ADDR_CTRL, `KEY_FIRST);
        wr(`ADDR_CTRL, `KEY_SECOND);
        wr(`ADDR_CTRL, code);
    endtask

    // refresh instruction as a one-cycle pulse
    task automatic refresh();
        @(posedge clk_sys);
        refresh_pulse <= 1'b1;
        @(posedge clk_sys);
        refresh_pulse <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== test/tb_watchdog_downcounter.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "watchdog_regs.svh"

module tb_watchdog_downcounter;
    logic        clk_sys, srst, always_on_option, timeout_reset_select, stop_mode;
    logic        debug_mode, ext_reset_event, gpio_recovery_event;
    logic        wr_en, rd_en, refresh_pulse, timeout_irq, device_reset_req;
    logic        stop_recovery_req, stop_osc_disable, watchdog_on, irq, rc_osc;
    logic [11:0] addr;
    logic [7:0]  wdata, rdata, d;
    logic [3:0]  rc_div;
    int          fails, check_count, k;
    int          pulses[3];

    cpu_model i_cpu (.clk_sys(clk_sys), .rdata(rdata), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .refresh_pulse(refresh_pulse));
    watchdog_downcounter i_dut (.clk_sys(clk_sys), .srst(srst), .rc_osc(rc_osc),
        .always_on_option(always_on_option), .timeout_reset_select(timeout_reset_select),
        .refresh_pulse(refresh_pulse), .stop_mode(stop_mode), .debug_mode(debug_mode),
        .ext_reset_event(ext_reset_event), .gpio_recovery_event(gpio_recovery_event),
        .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .timeout_irq(timeout_irq), .device_reset_req(device_reset_req),
        .stop_recovery_req(stop_recovery_req), .stop_osc_disable(stop_osc_disable),
        .watchdog_on(watchdog_on), .irq(irq));

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    // oscillator at one sixteenth of the clock, response pulse counters
    assign rc_osc = rc_div[3];
    always @(posedge clk_sys) begin
        rc_div <= rc_div + 4'h1;
        pulses[0] += int'(timeout_irq);
        pulses[1] += int'(device_reset_req);
        pulses[2] += int'(stop_recovery_req);
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        if (fails == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [7:0] exp);
        i_cpu.rd(a, d);
        check(d, exp);
    endtask

    // bounded wait for a response pulse, then let status settle
    task automatic wait_pulse(input int i, input int bound);
        int n;
        n = pulses[i];
        for (k = 0; k < bound && pulses[i] == n; k++) @(posedge clk_sys);
        if (pulses[i] == n) begin
            fails++;
            finish_test();
        end
        repeat (2) @(posedge clk_sys);
        #1;
    endtask

    task automatic ticks(input int n);
        repeat (n * 16) @(posedge clk_sys);
    endtask

    initial begin
        {srst, rc_div} = 5'h10;
        {always_on_option, timeout_reset_select, stop_mode, debug_mode} = 4'h0;
        {ext_reset_event, gpio_recovery_event, fails, check_count} = '0;
        pulses = '{0, 0, 0};
        repeat (6) @(posedge clk_sys);
        srst <= 1'b0;
        rdchk(`ADDR_CTRL, 8'h80);
        rdchk(`ADDR_CTRL, 8'h00);
        rdchk(12'hFFF, 8'h00);
        i_cpu.wr(`ADDR_IRQ_MASK, 8'h01);
        i_cpu.load(24'h000010);
        i_cpu.refresh();
        ticks(2);
        check({7'h00, watchdog_on}, 8'h01);
        rdchk(`ADDR_UPPER, 8'h00);
        // regular refreshes hold off the time-out
        repeat (4) begin
            ticks(8);
            i_cpu.refresh();
        end
        check(8'(pulses[0]), 8'h00);
        wait_pulse(0, 1000);
        check({7'h00, irq}, 8'h01);
        ticks(2);
        rdchk(`ADDR_UPPER, 8'hFF);
        rdchk(`ADDR_CTRL, 8'h20);
        rdchk(`ADDR_IRQ_STATUS, 8'h01);
        repeat (2) @(posedge clk_sys);
        check({7'h00, irq}, 8'h00);
        i_cpu.stop_cfg(`STOP_OFF_CODE);
        #1;
        check({7'h00, stop_osc_disable}, 8'h01);
        rdchk(`ADDR_CTRL, 8'h00);
        i_cpu.stop_cfg(`STOP_ON_CODE);
        #1;
        check({7'h00, stop_osc_disable}, 8'h00);
        // stray write breaks the unlock; later upper write must not land
        timeout_reset_select <= 1'b1;
        i_cpu.wr(`ADDR_CTRL, `KEY_FIRST);
        i_cpu.wr(`ADDR_CTRL, `KEY_SECOND);
        i_cpu.wr(`ADDR_LOW, 8'h77);
        i_cpu.wr(`ADDR_UPPER, 8'h01);
        i_cpu.refresh();
        ticks(2);
        rdchk(`ADDR_UPPER, 8'h00);
        // refresh at count two is ignored, time-out follows within two ticks
        for (k = 0; k < 400 && d !== 8'h02; k++) i_cpu.rd(`ADDR_LOW, d);
        check(d, 8'h02);
        i_cpu.refresh();
        wait_pulse(1, 60);
        rdchk(`ADDR_CTRL, 8'h20);
        stop_mode <= 1'b1;
        i_cpu.refresh();
        wait_pulse(2, 1000);
        rdchk(`ADDR_CTRL, 8'h60);
        // debug mode keeps the counter from expiring
        {stop_mode, timeout_reset_select, debug_mode} <= 3'h1;
        i_cpu.refresh();
        k = pulses[0];
        ticks(40);
        check(8'(pulses[0] - k), 8'h00);
        debug_mode <= 1'b0;
        wait_pulse(0, 1000);
        ext_reset_event <= 1'b1;
        @(posedge clk_sys);
        ext_reset_event <= 1'b0;
        rdchk(`ADDR_CTRL, 8'h10);
        gpio_recovery_event <= 1'b1;
        @(posedge clk_sys);
        gpio_recovery_event <= 1'b0;
        rdchk(`ADDR_CTRL, 8'h40);
        // stop option freezes the running counter while in stop mode
        i_cpu.stop_cfg(`STOP_OFF_CODE);
        stop_mode <= 1'b1;
        i_cpu.rd(`ADDR_LOW, d);
        k = int'(d);
        ticks(4);
        rdchk(`ADDR_LOW, 8'(k));
        finish_test();
    end
endmodule
`default_nettype wire
